/* File: reload_timer_regs.vh */
// register map, field positions, reset values and prescaler taps of the reload timer
`ifndef RELOAD_TIMER_REGS_VH
`define RELOAD_TIMER_REGS_VH

`define ADDR_W              8
`define DATA_W              16
`define CHAN_N              2

// per-channel block: base = channel index times stride
`define CHAN_STRIDE         8'h10
`define OFF_CTRL            4'h0
`define OFF_RELOAD          4'h4
`define OFF_COUNT           4'h8
`define ADDR_INT_STATUS     8'h20
`define ADDR_INT_MASK       8'h24

// timer_control_status_reg fields
`define CTRL_SWTRIG         0
`define CTRL_ENABLE         1
`define CTRL_RELOAD_MODE    2
`define CTRL_CSEL_LO        3
`define CTRL_CSEL_HI        4
`define CTRL_EXTTRIG_EN     5
`define CTRL_IIO_EN         6
`define CTRL_BUSY           7
`define CTRL_W              8
`define CTRL_RESET          8'h00

// count clock select codes
`define CSEL_INT0           2'h0
`define CSEL_INT1           2'h1
`define CSEL_INT2           2'h2
`define CSEL_EVENT          2'h3

`define RELOAD_RESET        16'h0000
`define COUNT_RESET         16'hFFFF
`define INT_RESET           2'h0

// internal clock rates: one tick every 2^n machine clocks
`define PRESC_W             6
`define DIV0_BITS           1
`define DIV1_BITS           3
`define DIV2_BITS           5

`endif

/* File: timer_channel.v */
// one 16-bit down counter with one-shot and reload operation
`timescale 1ns/1ps

module timer_channel (
    input  wire        mclk,
    input  wire        reset,
    input  wire        enable,
    input  wire        reloadMode,
    input  wire        startPulse,
    input  wire        countTick,
    input  wire [15:0] reloadValue,
    output wire [15:0] count,
    output wire        busy,
    output wire        underflow
);

`include "reload_timer_regs.vh"

    localparam STOPPED = 2'b01;
    localparam RUNNING = 2'b10;

    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [15:0] count_r;
    reg  [15:0] count_nxt;
    reg         under_r;
    reg         under_nxt;

    always @* begin
        state_nxt = state_r;
        count_nxt = count_r;
        under_nxt = 1'b0;
        case (state_r)
            STOPPED: begin
                if (enable && startPulse) begin
                    count_nxt = reloadValue;
                    state_nxt = RUNNING;
                end
            end
            RUNNING: begin
                if (!enable) begin
                    state_nxt = STOPPED;
                end else if (startPulse) begin
                    // retrigger restarts from the reload value
                    count_nxt = reloadValue;
                end else if (countTick) begin
                    count_nxt = count_r - 16'h0001;
                    if (count_r == 16'h0000) begin
                        under_nxt = 1'b1;
                        if (reloadMode) begin
                            count_nxt = reloadValue;
                        end else begin
                            state_nxt = STOPPED;
                        end
                    end
                end
            end
            default: begin
                state_nxt = STOPPED;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (reset) begin
            state_r <= STOPPED;
            count_r <= `COUNT_RESET;
            under_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            under_r <= under_nxt;
        end
    end

    assign count     = count_r;
    assign busy      = state_r[1];
    assign underflow = under_r;

endmodule

/* File: reload_down_timer.v */
// two-channel 16-bit reload down timer with register port and interrupt
//
// Summary of operation
// - count clock is one of three internal rates or external events
// - counting starts on software trigger or external trigger; in event mode only the software trigger starts it
// - counter underflow raises an interrupt request
// - one-shot mode stops counting at underflow
// - reload mode copies reload value into counter and continues
// - clock select codes 00, 01, 10 choose internal rates
// - internal mode decrements once per selected internal tick
// - internal mode starts on software or external trigger edge
// - underflow request can start the intelligent I/O service
// - two independent timer channels are provided
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps

module reload_down_timer (
    input  wire        mclk,
    input  wire        reset,
    input  wire [7:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wrStrobe,
    input  wire        rdStrobe,
    output wire [15:0] rdata,
    input  wire [1:0]  eventClkIn,
    input  wire [1:0]  extTrigIn,
    output wire        irq,
    output wire [1:0]  iioRequest,
    output wire [1:0]  timerBusy
);

`include "reload_timer_regs.vh"

    // two-flop synchronisers and edge registers
    reg  [1:0]  eventMeta_r;
    reg  [1:0]  eventSync_r;
    reg  [1:0]  eventLast_r;
    reg  [1:0]  trigMeta_r;
    reg  [1:0]  trigSync_r;
    reg  [1:0]  trigLast_r;
    wire [1:0]  eventEdge;
    wire [1:0]  trigEdge;

    always @(posedge mclk) begin
        if (reset) begin
            eventMeta_r <= 2'h0;
            eventSync_r <= 2'h0;
            eventLast_r <= 2'h0;
            trigMeta_r  <= 2'h0;
            trigSync_r  <= 2'h0;
            trigLast_r  <= 2'h0;
        end else begin
            eventMeta_r <= eventClkIn;
            eventSync_r <= eventMeta_r;
            eventLast_r <= eventSync_r;
            trigMeta_r  <= extTrigIn;
            trigSync_r  <= trigMeta_r;
            trigLast_r  <= trigSync_r;
        end
    end

    // rising edges only, taken after the second flop
    assign eventEdge = eventSync_r & ~eventLast_r;
    assign trigEdge  = trigSync_r & ~trigLast_r;

    // free-running prescaler for the internal rates
    reg  [`PRESC_W-1:0] presc_r;
    wire [2:0]          internalTick;

    always @(posedge mclk) begin
        if (reset) begin
            presc_r <= {`PRESC_W{1'b0}};
        end else begin
            presc_r <= presc_r + 6'h01;
        end
    end

    assign internalTick[0] = &presc_r[`DIV0_BITS-1:0];
    assign internalTick[1] = &presc_r[`DIV1_BITS-1:0];
    assign internalTick[2] = &presc_r[`DIV2_BITS-1:0];

    // register port decode
    wire        chanArea;
    wire        chanIdx;
    wire [3:0]  chanOff;
    wire        wrStatus;
    wire        wrMask;
    wire        rdStatus;

    assign chanArea = (addr < `ADDR_INT_STATUS);
    assign chanIdx  = addr[4];
    assign chanOff  = addr[3:0];
    assign wrStatus = wrStrobe && (addr == `ADDR_INT_STATUS);
    assign wrMask   = wrStrobe && (addr == `ADDR_INT_MASK);
    assign rdStatus = rdStrobe && (addr == `ADDR_INT_STATUS);

    // per-channel registers and counters
    wire [2*`CTRL_W-1:0] ctrlFlat;
    wire [31:0]          readFlat;
    wire [1:0]           chanBusy;
    wire [1:0]           chanUnder;

    genvar ch;
    generate
        for (ch = 0; ch < `CHAN_N; ch = ch + 1) begin : chan
            reg  [`CTRL_W-1:0] ctrl_r;
            reg  [15:0]        reload_r;
            wire               selCtrl;
            wire               selReload;
            wire               swTrig;
            wire [1:0]         csel;
            wire               eventMode;
            wire               extStart;
            wire               startPulse;
            wire               enableNow;
            reg                countTick;
            wire [15:0]        countVal;
            reg  [15:0]        chanRead;

            assign selCtrl   = wrStrobe && chanArea && (chanIdx == ch)
                               && (chanOff == `OFF_CTRL);
            assign selReload = wrStrobe && chanArea && (chanIdx == ch)
                               && (chanOff == `OFF_RELOAD);
            assign swTrig    = selCtrl && wdata[`CTRL_SWTRIG];
            assign csel      = {ctrl_r[`CTRL_CSEL_HI], ctrl_r[`CTRL_CSEL_LO]};
            assign eventMode = (csel == `CSEL_EVENT);
            // a control write acts at its own edge: enable and trigger may share one write
            assign enableNow = selCtrl ? wdata[`CTRL_ENABLE] : ctrl_r[`CTRL_ENABLE];

            always @(posedge mclk) begin
                if (reset) begin
                    ctrl_r   <= `CTRL_RESET;
                    reload_r <= `RELOAD_RESET;
                end else begin
                    if (selCtrl) begin
                        // trigger and busy bits are not stored
                        ctrl_r <= wdata[`CTRL_W-1:0] & 8'h7E;
                    end
                    if (selReload) begin
                        reload_r <= wdata;
                    end
                end
            end

            // event mode ignores the external trigger
            assign extStart   = ctrl_r[`CTRL_EXTTRIG_EN] && !eventMode && trigEdge[ch];
            assign startPulse = swTrig || extStart;

            always @* begin
                case (csel)
                    `CSEL_INT0: begin
                        countTick = internalTick[0];
                    end
                    `CSEL_INT1: begin
                        countTick = internalTick[1];
                    end
                    `CSEL_INT2: begin
                        countTick = internalTick[2];
                    end
                    `CSEL_EVENT: begin
                        countTick = eventEdge[ch];
                    end
                    default: begin
                        countTick = 1'b0;
                    end
                endcase
            end

            timer_channel u_timer (
                .mclk        (mclk),
                .reset       (reset),
                .enable      (enableNow),
                .reloadMode  (ctrl_r[`CTRL_RELOAD_MODE]),
                .startPulse  (startPulse),
                .countTick   (countTick),
                .reloadValue (reload_r),
                .count       (countVal),
                .busy        (chanBusy[ch]),
                .underflow   (chanUnder[ch])
            );

            assign ctrlFlat[ch*`CTRL_W +: `CTRL_W] = ctrl_r;
            assign readFlat[ch*16 +: 16]           = chanRead;

            // channel read view; busy is taken live from the counter state
            always @* begin
                chanRead = 16'h0000;
                case (chanOff)
                    `OFF_CTRL: begin
                        chanRead = {8'h00, ctrl_r};
                        chanRead[`CTRL_BUSY] = chanBusy[ch];
                    end
                    `OFF_RELOAD: begin
                        chanRead = reload_r;
                    end
                    `OFF_COUNT: begin
                        chanRead = countVal;
                    end
                    default: begin
                        chanRead = 16'h0000;
                    end
                endcase
            end
        end
    endgenerate

    // interrupt status, mask and service requests
    reg  [1:0] intStatus_r;
    reg  [1:0] intStatus_nxt;
    reg  [1:0] intMask_r;
    reg  [1:0] iio_r;
    wire [1:0] iioEnable;

    always @* begin
        intStatus_nxt = intStatus_r;
        if (rdStatus) begin
            intStatus_nxt = 2'h0;
        end
        intStatus_nxt = intStatus_nxt | chanUnder;
    end

    assign iioEnable[0] = ctrlFlat[`CTRL_IIO_EN];
    assign iioEnable[1] = ctrlFlat[`CTRL_W + `CTRL_IIO_EN];

    always @(posedge mclk) begin
        if (reset) begin
            intStatus_r <= `INT_RESET;
            intMask_r   <= `INT_RESET;
            iio_r       <= 2'h0;
        end else begin
            intStatus_r <= intStatus_nxt;
            if (wrMask) begin
                intMask_r <= wdata[1:0];
            end
            iio_r <= chanUnder & iioEnable;
        end
    end

    assign irq        = |(intStatus_r & intMask_r);
    assign iioRequest = iio_r;
    assign timerBusy  = chanBusy;

    // registered read port
    reg [15:0] readMux;
    reg [15:0] rdata_r;

    always @* begin
        readMux = 16'h0000;
        if (chanArea) begin
            readMux = chanIdx ? readFlat[31:16] : readFlat[15:0];
        end else if (addr == `ADDR_INT_STATUS) begin
            readMux = {14'h0000, intStatus_r};
        end else if (addr == `ADDR_INT_MASK) begin
            readMux = {14'h0000, intMask_r};
        end
    end

    always @(posedge mclk) begin
        if (reset) begin
            rdata_r <= 16'h0000;
        end else if (rdStrobe) begin
            rdata_r <= readMux;
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    assign rdata = rdata_r;

endmodule

/* File: reload_down_timer_monitor.sv */
// port checker for the reload down timer
`timescale 1ns/1ps
`include "reload_timer_regs.vh"

module reload_down_timer_monitor (
    input logic        mclk,
    input logic        reset,
    input logic [7:0]  addr,
    input logic [15:0] wdata,
    input logic        wrStrobe,
    input logic        rdStrobe,
    input logic [15:0] rdata,
    input logic [1:0]  eventClkIn,
    input logic [1:0]  extTrigIn,
    input logic        irq,
    input logic [1:0]  iioRequest,
    input logic [1:0]  timerBusy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_startCh0;
        wrStrobe && addr == 8'h00 && wdata[1:0] == 2'h3;
    endsequence
    sequence s_stopCh0;
        wrStrobe && addr == 8'h00 && !wdata[`CTRL_ENABLE];
    endsequence
    sequence s_quietStatusRead;
        rdStrobe && addr == `ADDR_INT_STATUS && timerBusy == 2'h0 && $past(timerBusy) == 2'h0;
    endsequence

    a_rdata_idle_zero: assert property (!rdStrobe |=> rdata == 16'h0000)
        else $error("read data not zero outside read answer");
    a_unmapped_read: assert property (rdStrobe && addr == 8'h30 |=> rdata == 16'h0000)
        else $error("unmapped read returned data");
    a_iio_pulse_ch0: assert property (iioRequest[0] |=> !iioRequest[0])
        else $error("service request ch0 longer than one cycle");
    a_iio_pulse_ch1: assert property ($rose(iioRequest[1]) |=> $fell(iioRequest[1]))
        else $error("service request ch1 longer than one cycle");
    a_mask_off_irq: assert property (wrStrobe && addr == `ADDR_INT_MASK
        && wdata[1:0] == 2'h0 |=> !irq)
        else $error("interrupt high with all masked");
    a_status_read_clear: assert property (s_quietStatusRead |=> !irq)
        else $error("interrupt stays after status read");
    a_busy_on_start: assert property (s_startCh0 |=> timerBusy[0])
        else $error("channel 0 not busy after start");
    a_busy_off_stop: assert property (s_stopCh0 |=> !timerBusy[0] [*2])
        else $error("channel 0 still busy after disable");
endmodule

/* File: reload_down_timer_bench.sv */
// self-checking bench for the reload down timer
`timescale 1ns/1ps
`include "reload_timer_regs.vh"

module reload_down_timer_bench;
    logic        mclk;
    logic        reset;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wrStrobe;
    logic        rdStrobe;
    wire  [15:0] rdata;
    logic [1:0]  eventClkIn;
    logic [1:0]  extTrigIn;
    wire         irq;
    wire  [1:0]  iioRequest;
    wire  [1:0]  timerBusy;
    int          nMismatch = 0;
    int          checked = 0;
    int          iioCnt = 0;

    reload_down_timer dut_u (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdata(rdata), .eventClkIn(eventClkIn),
        .extTrigIn(extTrigIn), .irq(irq), .iioRequest(iioRequest), .timerBusy(timerBusy));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (iioRequest[0] === 1'b1) iioCnt <= iioCnt + 1;
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, nMismatch);
        if (nMismatch == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            nMismatch++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wrStrobe <= 1'b1;
        @(posedge mclk);
        wrStrobe <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        @(posedge mclk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge mclk);
        rdStrobe <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic pin(input int ch, input logic isEvt);
        @(posedge mclk);
        if (isEvt) eventClkIn[ch] <= 1'b1;
        else extTrigIn[ch] <= 1'b1;
        repeat (4) @(posedge mclk);
        eventClkIn <= 2'h0;
        extTrigIn <= 2'h0;
        repeat (4) @(posedge mclk);
        #1;
    endtask

    task automatic waitBusy(input int ch, input logic lvl, output int n);
        n = 0;
        while (timerBusy[ch] !== lvl) begin
            @(posedge mclk);
            #1;
            n++;
            if (n > 2000) begin
                $display("BAD t=%0t busy wait ran out", $time);
                nMismatch++;
                end_sim();
            end
        end
    endtask

    task automatic test_reset;
        rdc(8'h00, 16'h0000);
        rdc(8'h04, 16'h0000);
        rdc(8'h18, 16'hFFFF);
        rdc(`ADDR_INT_STATUS, 16'h0000);
        rdc(`ADDR_INT_MASK, 16'h0000);
        rdc(8'h30, 16'h0000);
        $display("test_reset done");
    endtask

    task automatic test_event;
        wr(`ADDR_INT_MASK, 16'h0001);
        wr(8'h04, 16'h0002);
        wr(8'h00, 16'h007E);
        pin(0, 1'b0);
        chk({15'h0, timerBusy[0]}, 16'h0000);
        wr(8'h00, 16'h007F);
        rdc(8'h08, 16'h0002);
        chk({15'h0, timerBusy[0]}, 16'h0001);
        pin(0, 1'b1);
        pin(0, 1'b1);
        rdc(8'h08, 16'h0000);
        pin(0, 1'b1);
        chk({15'h0, irq}, 16'h0001);
        chk(iioCnt[15:0], 16'h0001);
        wr(`ADDR_INT_MASK, 16'h0000);
        #1;
        chk({15'h0, irq}, 16'h0000);
        wr(`ADDR_INT_MASK, 16'h0001);
        #1;
        chk({15'h0, irq}, 16'h0001);
        rdc(`ADDR_INT_STATUS, 16'h0001);
        chk({15'h0, irq}, 16'h0000);
        rdc(8'h08, 16'h0002);
        chk({15'h0, timerBusy[0]}, 16'h0001);
        wr(8'h00, 16'h0000);
        #1;
        chk({15'h0, timerBusy[0]}, 16'h0000);
        $display("test_event done");
    endtask

    task automatic test_internal;
        int c;
        int n;
        int dv;
        wr(`ADDR_INT_MASK, 16'h0002);
        wr(8'h14, 16'h0003);
        for (c = 0; c < 3; c++) begin
            dv = 2 << (2 * c);
            wr(8'h10, 16'h0062 | 16'(c << 3));
            @(posedge mclk);
            extTrigIn[1] <= 1'b1;
            waitBusy(1, 1'b1, n);
            @(posedge mclk);
            extTrigIn <= 2'h0;
            waitBusy(1, 1'b0, n);
            chk({15'h0, n + 1 >= 3 * dv && n + 1 <= 4 * dv + 2}, 16'h0001);
            rdc(8'h18, 16'hFFFF);
            chk({15'h0, irq}, 16'h0001);
            rdc(`ADDR_INT_STATUS, 16'h0002);
            chk({15'h0, irq}, 16'h0000);
        end
        $display("test_internal done");
    endtask

    initial begin
        reset = 1'b1;
        addr = 8'h00;
        wdata = 16'h0000;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        eventClkIn = 2'h0;
        extTrigIn = 2'h0;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        test_reset();
        test_event();
        test_internal();
        end_sim();
    end
endmodule

bind reload_down_timer reload_down_timer_monitor mon_u (.mclk(mclk), .reset(reset),
    .addr(addr), .wdata(wdata), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdata(rdata),
    .eventClkIn(eventClkIn), .extTrigIn(extTrigIn), .irq(irq), .iioRequest(iioRequest),
    .timerBusy(timerBusy));
